// File: ppo_pkg.sv
// Package with constants for the port pin alternate override block
//
// Summary of operation
// - Pull-up override enable set: pull-up follows override value alone.
// - Without pull-up override, pull-up on only for direction/output/disable 0b010.
// - Direction override enable set: driver enable follows direction override value.
// - Without direction override, driver enable follows the pin direction bit.
// - Value override enable set with driver on: pin driven with override value.
// - Without value override, driver on: pin driven with output register bit.
// - Toggle override enable from a peripheral inverts the output register bit.
// - Input-enable override set: digital input enabled by override value only.
// - Without input-enable override, digital input enabled unless sleep clamp active.
// - Digital input to peripherals taken after the input gate, before the synchroniser.
// - Analog path connects straight to the pad, no digital gating.
// - Register strobes shared per port; clock, sleep, pull-up disable global; overrides per pin.
// - Port A pin n is converter channel n and pin change source n.
// - No override: direction bit high makes an output, low makes an input.
// - Writing one to an input register bit inverts that pin's output bit.
// - Sleep clamp is raised by the sleep controller in deep sleep states.
package ppo_pkg;

    // ==========================================================
    // Port shape
    localparam int PPO_PINS = 8;
    localparam int PPO_ADDR_W = 2;
    typedef logic [PPO_PINS-1:0] ppo_vec_type;
    typedef logic [PPO_ADDR_W-1:0] ppo_addr_type;

    // ==========================================================
    // Register offsets
    localparam ppo_addr_type PPO_ADDR_INPUT = 2'h0;
    localparam ppo_addr_type PPO_ADDR_DIR = 2'h1;
    localparam ppo_addr_type PPO_ADDR_OUTPUT = 2'h2;

    // ==========================================================
    // Reset values
    localparam ppo_vec_type PPO_DIR_RST = 8'h00;
    localparam ppo_vec_type PPO_OUT_RST = 8'h00;
    localparam ppo_vec_type PPO_SYNC_RST = 8'h00;
    localparam ppo_vec_type PPO_RDATA_RST = 8'h00;

    // ==========================================================
    // Pull-up pattern {direction, output, pull-up disable}
    localparam logic [2:0] PPO_PULLUP_PATTERN = 3'h2;

endpackage

// File: ppo_ovr_if.sv
// Interface carrying per-pin override controls and resolved pad controls
`timescale 1ns/100ps
`default_nettype none
interface ppo_ovr_if;
    import ppo_pkg::*;

    ppo_vec_type pullup_override_en;
    ppo_vec_type pullup_override_val;
    ppo_vec_type dir_override_en;
    ppo_vec_type dir_override_val;
    ppo_vec_type outval_override_en;
    ppo_vec_type outval_override_val;
    ppo_vec_type input_en_override_en;
    ppo_vec_type input_en_override_val;
    ppo_vec_type pin_direction_bit;
    ppo_vec_type pin_output_bit;
    logic global_pullup_disable;
    logic sleep_clamp;
    ppo_vec_type pad_in;
    ppo_vec_type pullup_on;
    ppo_vec_type drive_en;
    ppo_vec_type drive_val;
    ppo_vec_type input_en;
    ppo_vec_type raw_digital_in;

    modport ctrl (
        output pullup_override_en,
        output pullup_override_val,
        output dir_override_en,
        output dir_override_val,
        output outval_override_en,
        output outval_override_val,
        output input_en_override_en,
        output input_en_override_val,
        output pin_direction_bit,
        output pin_output_bit,
        output global_pullup_disable,
        output sleep_clamp,
        output pad_in,
        input pullup_on,
        input drive_en,
        input drive_val,
        input input_en,
        input raw_digital_in
    );

    modport mux (
        input pullup_override_en,
        input pullup_override_val,
        input dir_override_en,
        input dir_override_val,
        input outval_override_en,
        input outval_override_val,
        input input_en_override_en,
        input input_en_override_val,
        input pin_direction_bit,
        input pin_output_bit,
        input global_pullup_disable,
        input sleep_clamp,
        input pad_in,
        output pullup_on,
        output drive_en,
        output drive_val,
        output input_en,
        output raw_digital_in
    );

endinterface
`default_nettype wire

// File: ppo_pin_mux.sv
// Combinational override multiplexers for all pins of one port
`timescale 1ns/100ps
`default_nettype none
module ppo_pin_mux (
    ppo_ovr_if.mux ovr
);
    import ppo_pkg::*;

    // ==========================================================
    // Per-pin override selection
    genvar gi;
    generate
        for (gi = 0; gi < PPO_PINS; gi++) begin : g_pin
            wire logic [2:0] plain_pattern;
            wire logic plain_pullup;
            assign plain_pattern = {ovr.pin_direction_bit[gi], ovr.pin_output_bit[gi],
                                    ovr.global_pullup_disable};
            assign plain_pullup = (plain_pattern == PPO_PULLUP_PATTERN);
            assign ovr.pullup_on[gi] = ovr.pullup_override_en[gi] ?
                                       ovr.pullup_override_val[gi] : plain_pullup;
            assign ovr.drive_en[gi] = ovr.dir_override_en[gi] ?
                                      ovr.dir_override_val[gi] :
                                      ovr.pin_direction_bit[gi];
            assign ovr.drive_val[gi] = ovr.outval_override_en[gi] ?
                                       ovr.outval_override_val[gi] :
                                       ovr.pin_output_bit[gi];
            assign ovr.input_en[gi] = ovr.input_en_override_en[gi] ?
                                      ovr.input_en_override_val[gi] :
                                      ~ovr.sleep_clamp;
            assign ovr.raw_digital_in[gi] = ovr.pad_in[gi] & ovr.input_en[gi];
        end
    endgenerate

endmodule
`default_nettype wire

// File: ppo_port.sv
// Port with alternate function overrides, register port and pad controls
`timescale 1ns/100ps
`default_nettype none
module ppo_port (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire ppo_pkg::ppo_addr_type reg_addr,
    input wire ppo_pkg::ppo_vec_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ppo_pkg::ppo_vec_type reg_rdata,
    input wire logic global_pullup_disable,
    input wire logic sleep_clamp,
    input wire ppo_pkg::ppo_vec_type pullup_override_en,
    input wire ppo_pkg::ppo_vec_type pullup_override_val,
    input wire ppo_pkg::ppo_vec_type dir_override_en,
    input wire ppo_pkg::ppo_vec_type dir_override_val,
    input wire ppo_pkg::ppo_vec_type outval_override_en,
    input wire ppo_pkg::ppo_vec_type outval_override_val,
    input wire ppo_pkg::ppo_vec_type toggle_override_en,
    input wire ppo_pkg::ppo_vec_type input_en_override_en,
    input wire ppo_pkg::ppo_vec_type input_en_override_val,
    input wire ppo_pkg::ppo_vec_type pad_in,
    output ppo_pkg::ppo_vec_type pad_out,
    output ppo_pkg::ppo_vec_type pad_oe,
    output ppo_pkg::ppo_vec_type pad_pullup_en,
    output ppo_pkg::ppo_vec_type raw_digital_in,
    output ppo_pkg::ppo_vec_type pin_change_sources,
    output ppo_pkg::ppo_vec_type analog_pad_path,
    output ppo_pkg::ppo_vec_type pin_input_bit,
    output ppo_pkg::ppo_vec_type pin_direction_bit,
    output ppo_pkg::ppo_vec_type pin_output_bit
);
    import ppo_pkg::*;

    // ==========================================================
    // Register state
    ppo_vec_type dir_q;
    ppo_vec_type dir_d;
    ppo_vec_type out_q;
    ppo_vec_type out_d;
    ppo_vec_type sync1_q;
    ppo_vec_type sync2_q;
    ppo_vec_type sync3_q;
    ppo_vec_type pin_q;
    ppo_vec_type pin_d;
    ppo_vec_type rdata_q;
    ppo_vec_type rdata_d;
    ppo_ovr_if ovr ();

    // ==========================================================
    // Address decode, one strobe set shared by all pins
    wire logic sel_input;
    wire logic sel_dir;
    wire logic sel_output;
    wire logic wr_dir;
    wire logic wr_out;
    wire logic wr_pin;
    wire logic rd_dir;
    wire logic rd_out;
    wire logic rd_pin;
    assign sel_input = (reg_addr == PPO_ADDR_INPUT);
    assign sel_dir = (reg_addr == PPO_ADDR_DIR);
    assign sel_output = (reg_addr == PPO_ADDR_OUTPUT);
    assign wr_dir = reg_wr & sel_dir;
    assign wr_out = reg_wr & sel_output;
    assign wr_pin = reg_wr & sel_input;
    assign rd_dir = reg_rd & sel_dir;
    assign rd_out = reg_rd & sel_output;
    assign rd_pin = reg_rd & sel_input;

    // ==========================================================
    // Next register values
    wire ppo_vec_type out_written;
    wire ppo_vec_type sw_toggle;
    assign dir_d = wr_dir ? reg_wdata : dir_q;
    assign out_written = wr_out ? reg_wdata : out_q;
    assign sw_toggle = wr_pin ? reg_wdata : PPO_OUT_RST;
    assign out_d = out_written ^ sw_toggle ^ toggle_override_en;

    // ==========================================================
    // Input synchroniser: value taken once second and third stages agree
    wire ppo_vec_type sync_agree;
    assign sync_agree = ~(sync2_q ^ sync3_q);
    assign pin_d = (sync_agree & sync3_q) | (~sync_agree & pin_q);

    // ==========================================================
    // Read data, one cycle after the strobe, zero otherwise
    assign rdata_d = rd_dir ? dir_q :
                     rd_out ? out_q :
                     rd_pin ? pin_q : PPO_RDATA_RST;

    // ==========================================================
    // Flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= PPO_DIR_RST;
            out_q <= PPO_OUT_RST;
        end else begin
            dir_q <= dir_d;
            out_q <= out_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= PPO_SYNC_RST;
            sync2_q <= PPO_SYNC_RST;
            sync3_q <= PPO_SYNC_RST;
            pin_q <= PPO_SYNC_RST;
        end else begin
            sync1_q <= ovr.raw_digital_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= pin_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= PPO_RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Override multiplexers, per-pin controls from the peripherals
    assign ovr.pullup_override_en = pullup_override_en;
    assign ovr.pullup_override_val = pullup_override_val;
    assign ovr.dir_override_en = dir_override_en;
    assign ovr.dir_override_val = dir_override_val;
    assign ovr.outval_override_en = outval_override_en;
    assign ovr.outval_override_val = outval_override_val;
    assign ovr.input_en_override_en = input_en_override_en;
    assign ovr.input_en_override_val = input_en_override_val;
    assign ovr.pin_direction_bit = dir_q;
    assign ovr.pin_output_bit = out_q;
    assign ovr.global_pullup_disable = global_pullup_disable;
    assign ovr.sleep_clamp = sleep_clamp;
    assign ovr.pad_in = pad_in;

    ppo_pin_mux u_mux (
        .ovr(ovr)
    );

    // ==========================================================
    // Pad side: reset tri-states every pin and drops pull-ups
    wire ppo_vec_type rst_mask;
    assign rst_mask = {PPO_PINS{rst_n}};
    assign pad_oe = ovr.drive_en & rst_mask;
    assign pad_out = ovr.drive_val & ovr.drive_en & rst_mask;
    assign pad_pullup_en = ovr.pullup_on & rst_mask;
    assign raw_digital_in = ovr.raw_digital_in;
    assign pin_change_sources = ovr.raw_digital_in;
    assign analog_pad_path = pad_in;

    // ==========================================================
    // Register views
    assign reg_rdata = rdata_q;
    assign pin_input_bit = pin_q;
    assign pin_direction_bit = dir_q;
    assign pin_output_bit = out_q;

endmodule
`default_nettype wire

// File: ppo_port_asserts.sv
// Concurrent checks on the pad controls of the port override block
`timescale 1ns/100ps
`default_nettype none
module ppo_port_asserts (
    input wire logic core_clk, rst_n, reg_wr, global_pullup_disable, sleep_clamp,
    input wire ppo_pkg::ppo_addr_type reg_addr,
    input wire ppo_pkg::ppo_vec_type reg_wdata, pullup_override_en, pullup_override_val,
    input wire ppo_pkg::ppo_vec_type dir_override_en, dir_override_val, outval_override_en,
    input wire ppo_pkg::ppo_vec_type outval_override_val, toggle_override_en,
    input wire ppo_pkg::ppo_vec_type input_en_override_en, input_en_override_val, pad_in,
    input wire ppo_pkg::ppo_vec_type pad_out, pad_oe, pad_pullup_en, raw_digital_in,
    input wire ppo_pkg::ppo_vec_type pin_direction_bit, pin_output_bit
);
    import ppo_pkg::*;
    // ==========================================================
    // Expected mux results
    wire ppo_vec_type oe_e = (dir_override_en & dir_override_val)
        | (~dir_override_en & pin_direction_bit);
    wire ppo_vec_type out_e = (outval_override_en & outval_override_val)
        | (~outval_override_en & pin_output_bit);
    wire ppo_vec_type pu_e = ~pin_direction_bit & pin_output_bit & {8{~global_pullup_disable}};
    wire ppo_vec_type in_e = (input_en_override_en & input_en_override_val)
        | (~input_en_override_en & {8{~sleep_clamp}});
    wire wr_in = reg_wr && reg_addr == PPO_ADDR_INPUT;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Assertions
    drv_en_a: assert property (pad_oe == oe_e)
        else $error("pad_oe mismatch");
    drv_val_a: assert property (pad_out == (oe_e & out_e))
        else $error("pad_out mismatch");
    pu_ovr_a: assert property (
        ((pad_pullup_en ^ pullup_override_val) & pullup_override_en) == 0)
        else $error("pull-up override mismatch");
    pu_plain_a: assert property (
        ((pad_pullup_en ^ pu_e) & ~pullup_override_en) == 0)
        else $error("plain pull-up mismatch");
    in_en_a: assert property (raw_digital_in == (pad_in & in_e))
        else $error("input enable mismatch");
    tog_a: assert property (!reg_wr |=>
        pin_output_bit == ($past(pin_output_bit) ^ $past(toggle_override_en)))
        else $error("toggle mismatch");
    pin_wr_a: assert property (wr_in |=> pin_output_bit ==
        ($past(pin_output_bit) ^ $past(reg_wdata) ^ $past(toggle_override_en)))
        else $error("input write toggle mismatch");
    dir_wr_a: assert property (reg_wr && reg_addr == PPO_ADDR_DIR |=>
        pin_direction_bit == $past(reg_wdata))
        else $error("direction write mismatch");
    cover property (wr_in);
    cover property (|toggle_override_en);
    cover property (|(pullup_override_en & pad_pullup_en));
endmodule
bind ppo_port ppo_port_asserts u_chk (.*);
`default_nettype wire

// File: ppo_periph_model.sv
// Peripheral owning alternate functions on the port pins
`timescale 1ns/100ps
`default_nettype none
module ppo_periph_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] func,
    input wire ppo_pkg::ppo_vec_type mask, val, raw_digital_in,
    output ppo_pkg::ppo_vec_type pullup_override_en, pullup_override_val,
    output ppo_pkg::ppo_vec_type dir_override_en, dir_override_val,
    output ppo_pkg::ppo_vec_type outval_override_en, outval_override_val,
    output ppo_pkg::ppo_vec_type toggle_override_en, input_en_override_en,
    output ppo_pkg::ppo_vec_type input_en_override_val, sync_in
);
    import ppo_pkg::*;
    ppo_vec_type meta_q, sync_q;
    wire ppo_vec_type v = val & mask;
    // ==========================================================
    // Overrides only on owned pins, others tied low
    assign pullup_override_en = func[0] ? mask : '0;
    assign dir_override_en = func[1] ? mask : '0;
    assign outval_override_en = func[2] ? mask : '0;
    assign input_en_override_en = func[3] ? mask : '0;
    assign toggle_override_en = func[4] ? mask : '0;
    assign pullup_override_val = v;
    assign dir_override_val = v;
    assign outval_override_val = v;
    assign input_en_override_val = v;
    // ==========================================================
    // Own synchroniser on the raw pin input
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_digital_in;
            sync_q <= meta_q;
        end
    end
    assign sync_in = sync_q;
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the port override block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ppo_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd, global_pullup_disable, sleep_clamp;
    logic [4:0] func;
    ppo_addr_type reg_addr;
    ppo_vec_type reg_wdata, reg_rdata, pad_in, pad_out, pad_oe, pad_pullup_en, raw_digital_in;
    ppo_vec_type pin_change_sources, analog_pad_path, pin_input_bit, pin_direction_bit;
    ppo_vec_type pin_output_bit, mask, val, sync_in, pullup_override_en, pullup_override_val;
    ppo_vec_type dir_override_en, dir_override_val, outval_override_en, outval_override_val;
    ppo_vec_type toggle_override_en, input_en_override_en, input_en_override_val;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rows [8][8];
    ppo_port dut (.*);
    ppo_periph_model partner (.*);
    // ==========================================================
    // Tasks
    task automatic cmp(input ppo_vec_type e, input ppo_vec_type g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input ppo_addr_type a, input ppo_vec_type d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input ppo_addr_type a, output ppo_vec_type d);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock and timeout
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        ppo_vec_type r;
        rst_n = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = '0;
        reg_wdata = '0;
        global_pullup_disable = 1'h0;
        sleep_clamp = 1'h0;
        func = 5'h03;
        mask = 8'hff;
        val = 8'hff;
        pad_in = 8'ha5;
        // func mask val {pud,sleep} oe out pullup raw
        rows = '{'{8'h00, 8'hff, 8'h00, 8'h00, 8'h0f, 8'h05, 8'h30, 8'ha5},
                 '{8'h00, 8'hff, 8'h00, 8'h03, 8'h0f, 8'h05, 8'h00, 8'h00},
                 '{8'h01, 8'hff, 8'hc3, 8'h02, 8'h0f, 8'h05, 8'hc3, 8'ha5},
                 '{8'h02, 8'hf0, 8'h5a, 8'h00, 8'h5f, 8'h15, 8'h30, 8'ha5},
                 '{8'h06, 8'hff, 8'h5a, 8'h00, 8'h5a, 8'h5a, 8'h30, 8'ha5},
                 '{8'h08, 8'h0f, 8'hff, 8'h01, 8'h0f, 8'h05, 8'h30, 8'h05},
                 '{8'h04, 8'hff, 8'hff, 8'h00, 8'h0f, 8'h0f, 8'h30, 8'ha5},
                 '{8'h08, 8'hff, 8'h0f, 8'h00, 8'h0f, 8'h05, 8'h30, 8'h05}};
        repeat (2) @(negedge core_clk);
        cmp(8'h00, pad_oe);
        cmp(8'h00, pad_pullup_en);
        rst_n = 1'h1;
        @(posedge core_clk);
        func <= '0;
        rd(PPO_ADDR_DIR, r);
        cmp(PPO_DIR_RST, r);
        wr(PPO_ADDR_DIR, 8'h0f);
        wr(PPO_ADDR_OUTPUT, 8'h35);
        wr(2'h3, 8'hff);
        rd(2'h3, r);
        cmp(8'h00, r);
        rd(PPO_ADDR_OUTPUT, r);
        cmp(8'h35, r);
        $display("test reset and registers done");
        foreach (rows[i]) begin
            @(posedge core_clk);
            func <= rows[i][0][4:0];
            mask <= rows[i][1];
            val <= rows[i][2];
            global_pullup_disable <= rows[i][3][1];
            sleep_clamp <= rows[i][3][0];
            @(negedge core_clk);
            cmp(rows[i][4], pad_oe);
            cmp(rows[i][5], pad_out);
            cmp(rows[i][6], pad_pullup_en);
            cmp(rows[i][7], raw_digital_in);
            cmp(rows[i][7], pin_change_sources);
            cmp(8'ha5, analog_pad_path);
        end
        $display("test override rows done");
        @(posedge core_clk);
        func <= 5'h10;
        mask <= 8'h81;
        global_pullup_disable <= 1'h0;
        sleep_clamp <= 1'h0;
        @(posedge core_clk);
        func <= '0;
        @(negedge core_clk);
        cmp(8'hb4, pin_output_bit);
        wr(PPO_ADDR_INPUT, 8'h0f);
        @(negedge core_clk);
        cmp(8'hbb, pin_output_bit);
        $display("test toggles done");
        @(posedge core_clk);
        pad_in <= 8'h3c;
        repeat (4) @(posedge core_clk);
        rd(PPO_ADDR_INPUT, r);
        cmp(8'h3c, r);
        cmp(8'h3c, pin_input_bit);
        cmp(8'h3c, sync_in);
        $display("test pin input done");
        @(negedge core_clk);
        rst_n = 1'h0;
        #1;
        cmp(8'h00, pad_oe);
        cmp(8'h00, pin_output_bit);
        @(negedge core_clk);
        rst_n = 1'h1;
        @(negedge core_clk);
        cmp(PPO_DIR_RST, pin_direction_bit);
        cmp(8'h00, pad_oe);
        $display("test mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire
